// file: rtl/fast_comp_pkg.sv
// Package: register map, field layout and timing of the offset compensation
package fast_comp_pkg;
   localparam logic [7:0] CTRL_OFFSET      = 8'h36;
   localparam logic [7:0] X_CORR_OFFSET    = 8'h38;
   localparam logic [7:0] Y_CORR_OFFSET    = 8'h39;
   localparam logic [7:0] Z_CORR_OFFSET    = 8'h3a;
   localparam logic [7:0] CORR_RESET       = 8'h00;
   localparam int         CLEAR_BIT        = 7;
   localparam int         LAUNCH_HI        = 6;
   localparam int         LAUNCH_LO        = 5;
   localparam int         READY_BIT        = 4;
   localparam int         CLK_PERIOD_NS    = 100;
   // Settling time per sample before it is averaged
   localparam int         SETTLE_NS        = 400;
   localparam int         SETTLE_CYCLES    =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         AVG_SAMPLES_LOG2 = 3;
   localparam logic [3:0] AVG_SAMPLES      = 4'h8;

   typedef enum logic [1:0] {
      AXIS_NONE = 2'b00,
      AXIS_X    = 2'b01,
      AXIS_Y    = 2'b10,
      AXIS_Z    = 2'b11
   } axis_code_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SETTLE = 2'b01,
      ST_ACCUM  = 2'b10,
      ST_STORE  = 2'b11
   } comp_state_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } accel_t;
endpackage

// file: rtl/axis_offset_sub.sv
// Subtracts one axis correction from the filtered and unfiltered samples
`timescale 1ns/1ps
module axis_offset_sub
   import fast_comp_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int SHIFT    = 4
)(
   input  wire logic                ref_clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic [7:0]          corr_i,
   input  wire logic [SAMPLE_W-1:0] filt_i,
   input  wire logic [SAMPLE_W-1:0] raw_i,
   output logic      [SAMPLE_W-1:0] filt_o,
   output logic      [SAMPLE_W-1:0] raw_o
);
   logic [SAMPLE_W-1:0] corr_scaled;

   // Correction lsb is a fixed multiple of the sample lsb
   assign corr_scaled = SAMPLE_W'({{(SAMPLE_W-8){corr_i[7]}}, corr_i})
                        << SHIFT;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         filt_o <= '0;
         raw_o  <= '0;
      end
      else
      begin
         filt_o <= filt_i - corr_scaled;
         raw_o  <= raw_i - corr_scaled;
      end
   end
endmodule

// file: rtl/fast_offset_comp.sv
// Fast offset compensation: control register, correction store and engine
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fast_offset_comp
   import fast_comp_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int SHIFT    = 4
)(
   input  wire logic                ref_clk_i,
   input  wire logic                sys_rst_i,
   input  wire reg_req_t            req_i,
   input  wire accel_t              filt_i,
   input  wire accel_t              raw_i,
   input  wire logic [SAMPLE_W-1:0] target_x_i,
   input  wire logic [SAMPLE_W-1:0] target_y_i,
   input  wire logic [SAMPLE_W-1:0] target_z_i,
   output logic      [7:0]          rdata_o,
   output accel_t                   filt_o,
   output accel_t                   raw_o,
   output logic                     ready_o
);
   ////////////////////////////////////////////////////////////////////////////
   localparam int ACC_W = SAMPLE_W + AVG_SAMPLES_LOG2 + 1;

   logic [7:0]       corr [3];
   comp_state_t      state;
   axis_code_t       axis;
   logic [7:0]       wait_cnt;
   logic [3:0]       samp_cnt;
   logic [ACC_W-1:0] acc;
   logic [SAMPLE_W-1:0] sel_sample;
   logic [SAMPLE_W-1:0] sel_target;
   logic [SAMPLE_W-1:0] avg;
   logic [SAMPLE_W-1:0] next_err;
   logic [7:0]       next_corr;
   logic             ctrl_wr;
   logic             launch;

   function automatic logic [1:0] axis_index(input axis_code_t a);
      axis_index = 2'(a) - 2'h1;
   endfunction

   function automatic int corr_addr_index(input logic [7:0] addr);
      if (addr == X_CORR_OFFSET)
         corr_addr_index = 0;
      else if (addr == Y_CORR_OFFSET)
         corr_addr_index = 1;
      else if (addr == Z_CORR_OFFSET)
         corr_addr_index = 2;
      else
         corr_addr_index = 3;
   endfunction

   assign ctrl_wr = req_i.wr_en && req_i.addr == CTRL_OFFSET;
   // Launch while busy is ignored, protecting a run already under way
   assign launch  = ctrl_wr && state == ST_IDLE &&
                    req_i.wdata[LAUNCH_HI:LAUNCH_LO] != AXIS_NONE;

   always_comb
   begin
      case (axis)
         AXIS_X:  sel_sample = filt_i.x;
         AXIS_Y:  sel_sample = filt_i.y;
         AXIS_Z:  sel_sample = filt_i.z;
         default: sel_sample = '0;
      endcase
      case (axis)
         AXIS_X:  sel_target = target_x_i;
         AXIS_Y:  sel_target = target_y_i;
         AXIS_Z:  sel_target = target_z_i;
         default: sel_target = '0;
      endcase
   end

   // Average of filtered samples minus target, in correction lsb, saturated
   assign avg      = SAMPLE_W'(acc >> AVG_SAMPLES_LOG2);
   // Signed shift, so a level below target gives a negative correction
   assign next_err = SAMPLE_W'($signed(avg - sel_target) >>> SHIFT);
   always_comb
   begin
      if ($signed(next_err) > $signed(SAMPLE_W'(127)))
         next_corr = 8'h7f;
      else if ($signed(next_err) < $signed(-SAMPLE_W'(128)))
         next_corr = 8'h80;
      else
         next_corr = next_err[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run sequencer
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state    <= ST_IDLE;
         axis     <= AXIS_NONE;
         wait_cnt <= 8'h00;
         samp_cnt <= 4'h0;
         acc      <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (launch)
               begin
                  axis     <= axis_code_t'(req_i.wdata[LAUNCH_HI:LAUNCH_LO]);
                  state    <= ST_SETTLE;
                  wait_cnt <= 8'h00;
                  samp_cnt <= 4'h0;
                  acc      <= '0;
               end
            end
            ST_SETTLE:
            begin
               wait_cnt <= wait_cnt + 8'h01;
               if (wait_cnt == 8'(SETTLE_CYCLES - 1))
                  state <= ST_ACCUM;
            end
            ST_ACCUM:
            begin
               // Uncorrected input, so the old correction does not bias it
               acc      <= acc + ACC_W'($signed(sel_sample));
               samp_cnt <= samp_cnt + 4'h1;
               wait_cnt <= 8'h00;
               if (samp_cnt == AVG_SAMPLES - 4'h1)
                  state <= ST_STORE;
               else
                  state <= ST_SETTLE;
            end
            ST_STORE:
               state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Correction store: clear beats engine, engine beats software
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         for (int i = 0; i < 3; i++)
            corr[i] <= CORR_RESET;
      end
      else if (ctrl_wr && req_i.wdata[CLEAR_BIT])
      begin
         for (int i = 0; i < 3; i++)
            corr[i] <= CORR_RESET;
      end
      else if (state == ST_STORE)
         corr[axis_index(axis)] <= next_corr;
      else if (req_i.wr_en && corr_addr_index(req_i.addr) < 3)
         corr[corr_addr_index(req_i.addr)] <= req_i.wdata;
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ready_o <= 1'b1;
      else if (launch)
         ready_o <= 1'b0;
      else if (state == ST_STORE)
         ready_o <= 1'b1;
   end

   // Launch and clear bits read as zero: they are pulses, not storage
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_o <= 8'h00;
      else if (req_i.rd_en)
      begin
         if (req_i.addr == CTRL_OFFSET)
            rdata_o <= 8'(ready_o) << READY_BIT;
         else if (corr_addr_index(req_i.addr) < 3)
            rdata_o <= corr[corr_addr_index(req_i.addr)];
         else
            rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   axis_offset_sub #(.SAMPLE_W(SAMPLE_W), .SHIFT(SHIFT)) u_sub_x (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .corr_i    (corr[0]),
      .filt_i    (filt_i.x),
      .raw_i     (raw_i.x),
      .filt_o    (filt_o.x),
      .raw_o     (raw_o.x)
   );
   axis_offset_sub #(.SAMPLE_W(SAMPLE_W), .SHIFT(SHIFT)) u_sub_y (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .corr_i    (corr[1]),
      .filt_i    (filt_i.y),
      .raw_i     (raw_i.y),
      .filt_o    (filt_o.y),
      .raw_o     (raw_o.y)
   );
   axis_offset_sub #(.SAMPLE_W(SAMPLE_W), .SHIFT(SHIFT)) u_sub_z (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .corr_i    (corr[2]),
      .filt_i    (filt_i.z),
      .raw_i     (raw_i.z),
      .filt_o    (filt_o.z),
      .raw_o     (raw_o.z)
   );

   ////////////////////////////////////////////////////////////////////////////
   clear_all_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      ctrl_wr && req_i.wdata[CLEAR_BIT] |=> corr[0] == 8'h00 &&
      corr[1] == 8'h00 && corr[2] == 8'h00)
      else $error("clear-all did not zero corrections");
   clear_zero_keeps_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ctrl_wr && !req_i.wdata[CLEAR_BIT] && state != ST_STORE
      |=> $stable(corr[0]) && $stable(corr[1]) && $stable(corr[2]))
      else $error("clear bit 0 changed corrections");
   launch_axis_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      launch |=> axis == $past(req_i.wdata[LAUNCH_HI:LAUNCH_LO]))
      else $error("wrong axis launched");
   no_launch_zero_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      state == ST_IDLE && !launch |=> state == ST_IDLE)
      else $error("run started without a launch code");
   ready_busy_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      launch |=> !ready_o ##1 (!ready_o)[*2])
      else $error("ready high during run");
   ready_idle_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      state == ST_IDLE && !$past(state == ST_STORE) |-> ready_o)
      else $error("ready low while idle");
   run_finish_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      launch |-> ##[40:60] ready_o)
      else $error("run did not finish in time");
   store_value_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      state == ST_STORE && !ctrl_wr |=> corr[axis_index(axis)] ==
      $past(next_corr))
      else $error("computed correction not stored");
   direct_write_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      req_i.wr_en && req_i.addr == Y_CORR_OFFSET && state != ST_STORE
      |=> corr[1] == $past(req_i.wdata))
      else $error("direct correction write lost");
   sub_x_a: assert property (@(posedge ref_clk_i)
      disable iff (sys_rst_i)
      ##1 filt_o.x == SAMPLE_W'($past(filt_i.x) -
      (SAMPLE_W'({{(SAMPLE_W-8){$past(corr[0][7])}}, $past(corr[0])})
      << SHIFT)))
      else $error("x correction not subtracted");

   run_x_c:   cover property (@(posedge ref_clk_i) launch && axis == AXIS_NONE
      ##1 axis == AXIS_X);
   run_done_c: cover property (@(posedge ref_clk_i) state == ST_STORE);
   clear_c:   cover property (@(posedge ref_clk_i)
      ctrl_wr && req_i.wdata[CLEAR_BIT]);
   busy_try_c: cover property (@(posedge ref_clk_i)
      ctrl_wr && !ready_o && req_i.wdata[LAUNCH_HI:LAUNCH_LO] != 2'b00);
endmodule

// file: tb/fast_offset_comp_tb_top.sv
// Self-checking testbench for the fast offset compensation block
`timescale 1ns/1ps
module fast_offset_comp_tb_top;
   import fast_comp_pkg::*;
   logic        ref_clk;
   logic        sys_rst;
   reg_req_t    req;
   accel_t      filt_in;
   accel_t      raw_in;
   logic [15:0] tgt_x;
   logic [15:0] tgt_y;
   logic [15:0] tgt_z;
   logic [7:0]  rdata;
   accel_t      filt_out;
   accel_t      raw_out;
   logic        ready;
   int          err_total;
   int          n_tests;
   int          cyc;

   fast_offset_comp u_fast_offset_comp (
      .ref_clk_i  (ref_clk),
      .sys_rst_i  (sys_rst),
      .req_i      (req),
      .filt_i     (filt_in),
      .raw_i      (raw_in),
      .target_x_i (tgt_x),
      .target_y_i (tgt_y),
      .target_z_i (tgt_z),
      .rdata_o    (rdata),
      .filt_o     (filt_out),
      .raw_o      (raw_out),
      .ready_o    (ready)
   );

   always #50 ref_clk = ~ref_clk;

   // Hang guard: whole run is a few hundred cycles
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         summarize();
      end
   end

   /////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      req.wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      req.rd_en <= 1'b0;
      @(negedge ref_clk);
      d = rdata;
   endtask

   /////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] v;
      rd(CTRL_OFFSET, v);
      chk8(v, 8'h10);
      for (int i = 0; i < 3; i++)
      begin
         rd(X_CORR_OFFSET + 8'(i), v);
         chk8(v, CORR_RESET);
      end
      rd(8'h37, v);
      chk8(v, 8'h00);
      $display("test reset done");
   endtask

   // Extreme codes: sign extension slips show up as wrong high bits
   task automatic t_direct;
      logic [7:0] v;
      @(posedge ref_clk);
      filt_in <= {16'h0000, 16'h1000, 16'h0020};
      raw_in <= {16'h0000, 16'h1000, 16'h0020};
      wr(X_CORR_OFFSET, 8'h80);
      wr(Y_CORR_OFFSET, 8'h7f);
      wr(Z_CORR_OFFSET, 8'h01);
      wr(8'h37, 8'h55);
      rd(X_CORR_OFFSET, v);
      chk8(v, 8'h80);
      rd(Y_CORR_OFFSET, v);
      chk8(v, 8'h7f);
      chk16(filt_out.x, 16'h0800);
      chk16(raw_out.x, 16'h0800);
      chk16(filt_out.y, 16'h0810);
      chk16(raw_out.y, 16'h0810);
      chk16(filt_out.z, 16'h0010);
      chk16(raw_out.z, 16'h0010);
      $display("test direct done");
   endtask

   task automatic t_clear;
      logic [7:0] v;
      wr(CTRL_OFFSET, 8'h00);
      rd(Z_CORR_OFFSET, v);
      chk8(v, 8'h01);
      chk8({7'h00, ready}, 8'h01);
      wr(CTRL_OFFSET, 8'h80);
      for (int i = 0; i < 3; i++)
      begin
         rd(X_CORR_OFFSET + 8'(i), v);
         chk8(v, 8'h00);
      end
      rd(CTRL_OFFSET, v);
      chk8(v, 8'h10);
      $display("test clear done");
   endtask

   task automatic run_axis(input logic [1:0] code, input logic [7:0] a,
                           input logic [7:0] exp);
      logic [7:0] v;
      int         k;
      wr(CTRL_OFFSET, {1'b0, code, 5'h00});
      @(negedge ref_clk);
      chk8({7'h00, ready}, 8'h00);
      rd(CTRL_OFFSET, v);
      chk8(v, 8'h00);
      k = 0;
      // No new launch until ready is back
      while (ready !== 1'b1 && k < 200)
      begin
         @(negedge ref_clk);
         k++;
      end
      chk8({7'h00, ready}, 8'h01);
      rd(a, v);
      chk8(v, exp);
   endtask

   // Large z offset must saturate rather than wrap
   task automatic t_launch;
      @(posedge ref_clk);
      filt_in <= {16'h0050, 16'h0000, 16'h7100};
      raw_in <= {16'h1000, 16'h0000, 16'h0000};
      run_axis(AXIS_X, X_CORR_OFFSET, 8'h05);
      run_axis(AXIS_Y, Y_CORR_OFFSET, 8'hfb);
      run_axis(AXIS_Z, Z_CORR_OFFSET, 8'h7f);
      @(negedge ref_clk);
      chk16(filt_out.x, 16'h0000);
      chk16(raw_out.x, 16'h0fb0);
      chk16(raw_out.y, 16'h0050);
      $display("test launch done");
   endtask

   /////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      req = '0;
      filt_in = '0;
      raw_in = '0;
      tgt_x = 16'h0000;
      tgt_y = 16'h0050;
      tgt_z = 16'h0100;
      err_total = 0;
      n_tests = 0;
      cyc = 0;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_direct();
      t_clear();
      t_launch();
      summarize();
   end
endmodule
